// file: inc/fspc_pkg.sv
// constants, types and register map of the flash self-programming control
package fspc_pkg;

   // ----------------------------------------------------------
   // register indices on the special function register port
   // ----------------------------------------------------------
   localparam int          SEL_W          = 4;
   localparam logic [3:0]  IDX_CTRL       = 4'h0;
   localparam logic [3:0]  IDX_CHIP_RST   = 4'h1;
   localparam logic [3:0]  IDX_PTIME      = 4'h2;
   localparam logic [3:0]  IDX_ADDR_LO    = 4'h3;
   localparam logic [3:0]  IDX_ADDR_HI    = 4'h4;
   localparam logic [3:0]  IDX_W0_LO      = 4'h5;
   localparam logic [3:0]  IDX_W0_HI      = 4'h6;
   localparam logic [3:0]  IDX_W1_LO      = 4'h7;
   localparam logic [3:0]  IDX_W1_HI      = 4'h8;
   localparam logic [3:0]  IDX_W2_LO      = 4'h9;
   localparam logic [3:0]  IDX_W2_HI      = 4'hA;
   localparam logic [3:0]  IDX_W3_LO      = 4'hB;
   localparam logic [3:0]  IDX_W3_HI      = 4'hC;

   // ----------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------
   localparam int          B_EN           = 7;
   localparam int          B_MODE_HI      = 6;
   localparam int          B_MODE_LO      = 4;
   localparam int          B_TRIG         = 3;
   localparam int          B_WSTART       = 2;
   localparam int          B_RALLOW       = 1;
   localparam int          B_RSTART       = 0;
   localparam int          B_PTSEL        = 1;
   localparam int          B_BCLR         = 0;
   localparam int          ADDR_W         = 13;
   localparam int          PAGE_W         = 5;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [4:0]  PAGE_LAST      = 5'h1F;

   // ----------------------------------------------------------
   // operation codes, keys and unlock pattern
   // ----------------------------------------------------------
   localparam logic [2:0]  MODE_WRITE     = 3'h0;
   localparam logic [2:0]  MODE_ERASE     = 3'h1;
   localparam logic [2:0]  MODE_READ      = 3'h3;
   localparam logic [2:0]  MODE_UNLOCK    = 3'h6;
   localparam logic [7:0]  CHIP_RST_KEY   = 8'h55;
   localparam logic [7:0]  PAT_W1_LO      = 8'h00;
   localparam logic [7:0]  PAT_W2_LO      = 8'h0D;
   localparam logic [7:0]  PAT_W3_LO      = 8'hC3;
   localparam logic [7:0]  PAT_W1_HI      = 8'h04;
   localparam logic [7:0]  PAT_W2_HI      = 8'h09;
   localparam logic [7:0]  PAT_W3_HI      = 8'h40;

   // ----------------------------------------------------------
   // timing: times in ns, counts derived from the clock period
   // ----------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          ERASE_T0_NS    = 3_200_000;
   localparam int          WRITE_T0_NS    = 2_200_000;
   localparam int          ERASE_T1_NS    = 3_700_000;
   localparam int          WRITE_T1_NS    = 3_000_000;
   localparam int          ERASE_T0_CYC   = ERASE_T0_NS / CLK_PERIOD_NS;
   localparam int          WRITE_T0_CYC   = WRITE_T0_NS / CLK_PERIOD_NS;
   localparam int          ERASE_T1_CYC   = ERASE_T1_NS / CLK_PERIOD_NS;
   localparam int          WRITE_T1_CYC   = WRITE_T1_NS / CLK_PERIOD_NS;
   localparam int          READ_CYC       = 4;
   localparam int          UNLOCK_CYC     = 2048;
   localparam int          CNT_W          = 17;
   localparam int          TMR_W          = 16;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_ERASE,
      ST_WRITE,
      ST_CLEAR
   } fspc_state_t;

endpackage

// file: src/fspc_wbuf.sv
// page write buffer memory with registered read data
module fspc_wbuf
   import fspc_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic             sys_clk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ----------------------------------------------------------
   // storage, one write and one registered read per cycle
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // fspc_wbuf

// file: src/fspc_ctrl.sv
// flash self-programming control: registers, unlock and sequencer
module fspc_ctrl
   import fspc_pkg::*;
#(
   parameter logic [CNT_W-1:0] ERASE0_CYC = CNT_W'(ERASE_T0_CYC),
   parameter logic [CNT_W-1:0] WRITE0_CYC = CNT_W'(WRITE_T0_CYC),
   parameter logic [CNT_W-1:0] ERASE1_CYC = CNT_W'(ERASE_T1_CYC),
   parameter logic [CNT_W-1:0] WRITE1_CYC = CNT_W'(WRITE_T1_CYC),
   parameter logic [CNT_W-1:0] RD_CYC     = CNT_W'(READ_CYC),
   parameter logic [TMR_W-1:0] UNLOCK_WIN = TMR_W'(UNLOCK_CYC)
) (
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic [SEL_W-1:0]  sfr_sel,
   input  wire logic              sfr_wr,
   input  wire logic [7:0]        sfr_wdata,
   output logic      [7:0]        sfr_rdata,
   output logic      [ADDR_W-1:0] flash_addr,
   output logic                   flash_rd_en,
   output logic                   flash_erase_en,
   output logic                   flash_prog_en,
   input  wire logic [15:0]       flash_rd_data,
   input  wire logic [PAGE_W-1:0] wb_rd_idx,
   output logic      [15:0]       wb_rd_data,
   output logic                   cpu_halt,
   output logic                   chip_reset
);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   fspc_state_t       st_r, st_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic [TMR_W-1:0]  tmr_r, tmr_nxt;
   logic              en_r, en_nxt;
   logic [2:0]        mode_r, mode_nxt;
   logic              trig_r, trig_nxt;
   logic              rallow_r, rallow_nxt;
   logic              ptsel_r, ptsel_nxt;
   logic              bclr_r, bclr_nxt;
   logic [7:0]        crst_r, crst_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [7:0]        dlo_r [4];
   logic [7:0]        dhi_r [4];
   logic [7:0]        dlo_nxt [4];
   logic [7:0]        dhi_nxt [4];
   logic [7:0]        rdata_nxt;
   logic              halt_nxt, rd_en_nxt, er_en_nxt, pg_en_nxt, crst_p_nxt;
   logic              wb_we;
   logic [PAGE_W-1:0] wb_waddr;
   logic [15:0]       wb_wdata;
   logic              pat_ok, wr_ctrl, w0hi_wr;

   // unlock pattern compare over words one to three
   assign pat_ok = (dlo_r[1] == PAT_W1_LO) && (dlo_r[2] == PAT_W2_LO) &&
                   (dlo_r[3] == PAT_W3_LO) && (dhi_r[1] == PAT_W1_HI) &&
                   (dhi_r[2] == PAT_W2_HI) && (dhi_r[3] == PAT_W3_HI);
   assign wr_ctrl = sfr_wr && (sfr_sel == IDX_CTRL);
   assign w0hi_wr = sfr_wr && (sfr_sel == IDX_W0_HI);

   // ----------------------------------------------------------
   // next-state logic for registers and sequencer
   // ----------------------------------------------------------
   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      tmr_nxt    = tmr_r;
      en_nxt     = en_r;
      mode_nxt   = mode_r;
      trig_nxt   = trig_r;
      rallow_nxt = rallow_r;
      ptsel_nxt  = ptsel_r;
      bclr_nxt   = bclr_r;
      crst_nxt   = crst_r;
      addr_nxt   = addr_r;
      dlo_nxt    = dlo_r;
      dhi_nxt    = dhi_r;
      crst_p_nxt = 1'b0;
      wb_we      = 1'b0;
      wb_waddr   = addr_r[PAGE_W-1:0];
      wb_wdata   = {sfr_wdata, dlo_r[0]};

      // software register writes
      if (sfr_wr && (sfr_sel == IDX_CTRL)) begin
         if (!sfr_wdata[B_EN]) begin
            en_nxt = 1'b0;
         end
         mode_nxt   = sfr_wdata[B_MODE_HI:B_MODE_LO];
         rallow_nxt = sfr_wdata[B_RALLOW];
         if (sfr_wdata[B_TRIG] && !trig_r) begin
            trig_nxt = 1'b1;
            tmr_nxt  = UNLOCK_WIN;
         end
      end else if (sfr_wr && (sfr_sel == IDX_CHIP_RST)) begin
         crst_nxt   = sfr_wdata;
         crst_p_nxt = (sfr_wdata == CHIP_RST_KEY);
      end else if (sfr_wr && (sfr_sel == IDX_PTIME)) begin
         ptsel_nxt = sfr_wdata[B_PTSEL];
         if (sfr_wdata[B_BCLR] && (st_r == ST_IDLE)) begin
            bclr_nxt = 1'b1;
            st_nxt   = ST_CLEAR;
            cnt_nxt  = '0;
         end
      end else if (sfr_wr && (sfr_sel == IDX_ADDR_LO)) begin
         addr_nxt[7:0] = sfr_wdata;
      end else if (sfr_wr && (sfr_sel == IDX_ADDR_HI)) begin
         addr_nxt[ADDR_W-1:8] = sfr_wdata[ADDR_W-9:0];
      end else if (sfr_wr && (sfr_sel == IDX_W0_LO)) begin
         dlo_nxt[0] = sfr_wdata;
      end else if (w0hi_wr) begin
         dhi_nxt[0] = sfr_wdata;
         wb_we      = en_r;
         if (addr_r[PAGE_W-1:0] != PAGE_LAST) begin
            addr_nxt = addr_r + ADDR_W'(1);
         end
      end else if (sfr_wr && (sfr_sel == IDX_W1_LO)) begin
         dlo_nxt[1] = sfr_wdata;
      end else if (sfr_wr && (sfr_sel == IDX_W1_HI)) begin
         dhi_nxt[1] = sfr_wdata;
      end else if (sfr_wr && (sfr_sel == IDX_W2_LO)) begin
         dlo_nxt[2] = sfr_wdata;
      end else if (sfr_wr && (sfr_sel == IDX_W2_HI)) begin
         dhi_nxt[2] = sfr_wdata;
      end else if (sfr_wr && (sfr_sel == IDX_W3_LO)) begin
         dlo_nxt[3] = sfr_wdata;
      end else if (sfr_wr && (sfr_sel == IDX_W3_HI)) begin
         dhi_nxt[3] = sfr_wdata;
      end

      // unlock window: hardware set wins over a clear
      if (trig_r) begin
         if ((mode_r == MODE_UNLOCK) && pat_ok) begin
            en_nxt = 1'b1;
         end
         if (tmr_r == '0) begin
            trig_nxt = 1'b0;
         end else begin
            tmr_nxt = tmr_r - TMR_W'(1);
         end
      end

      // operation launch from the control register
      if (wr_ctrl && (st_r == ST_IDLE)) begin
         if (sfr_wdata[B_WSTART] && en_r &&
             (sfr_wdata[B_MODE_HI:B_MODE_LO] == MODE_WRITE)) begin
            st_nxt  = ST_WRITE;
            cnt_nxt = (ptsel_r ? WRITE1_CYC : WRITE0_CYC) - CNT_W'(1);
         end else if (sfr_wdata[B_WSTART] && en_r &&
                      (sfr_wdata[B_MODE_HI:B_MODE_LO] == MODE_ERASE)) begin
            st_nxt  = ST_ERASE;
            cnt_nxt = (ptsel_r ? ERASE1_CYC : ERASE0_CYC) - CNT_W'(1);
         end else if (sfr_wdata[B_RSTART] && rallow_r &&
                      (sfr_wdata[B_MODE_HI:B_MODE_LO] == MODE_READ)) begin
            st_nxt  = ST_READ;
            cnt_nxt = RD_CYC - CNT_W'(1);
         end
      end

      // sequencer
      case (st_r)
         ST_READ: begin
            if (cnt_r == '0) begin
               st_nxt     = ST_IDLE;
               dlo_nxt[0] = flash_rd_data[7:0];
               dhi_nxt[0] = flash_rd_data[15:8];
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_ERASE: begin
            if (cnt_r == '0) begin
               st_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_WRITE: begin
            if (cnt_r == '0) begin
               st_nxt  = ST_CLEAR;
               cnt_nxt = '0;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_CLEAR: begin
            wb_we    = 1'b1;
            wb_waddr = cnt_r[PAGE_W-1:0];
            wb_wdata = '0;
            if (cnt_r[PAGE_W-1:0] == PAGE_LAST) begin
               st_nxt   = ST_IDLE;
               bclr_nxt = 1'b0;
            end else begin
               cnt_nxt = cnt_r + CNT_W'(1);
            end
         end
         default: begin
         end
      endcase

      // registered outputs follow the next state
      halt_nxt  = (st_nxt == ST_READ) || (st_nxt == ST_ERASE) ||
                  (st_nxt == ST_WRITE);
      rd_en_nxt = (st_nxt == ST_READ);
      er_en_nxt = (st_nxt == ST_ERASE);
      pg_en_nxt = (st_nxt == ST_WRITE);
   end

   // ----------------------------------------------------------
   // read-back mux, upper unimplemented bits return zero
   // ----------------------------------------------------------
   always_comb begin
      rdata_nxt = RST_BYTE;
      if (sfr_sel == IDX_CTRL) begin
         rdata_nxt = {en_r, mode_r, trig_r,
                      (st_r == ST_WRITE) || (st_r == ST_ERASE),
                      rallow_r, (st_r == ST_READ)};
      end else if (sfr_sel == IDX_CHIP_RST) begin
         rdata_nxt = crst_r;
      end else if (sfr_sel == IDX_PTIME) begin
         rdata_nxt = {6'h00, ptsel_r, bclr_r};
      end else if (sfr_sel == IDX_ADDR_LO) begin
         rdata_nxt = addr_r[7:0];
      end else if (sfr_sel == IDX_ADDR_HI) begin
         rdata_nxt = {3'h0, addr_r[ADDR_W-1:8]};
      end else if (sfr_sel == IDX_W0_LO) begin
         rdata_nxt = dlo_r[0];
      end else if (sfr_sel == IDX_W0_HI) begin
         rdata_nxt = dhi_r[0];
      end else if (sfr_sel == IDX_W1_LO) begin
         rdata_nxt = dlo_r[1];
      end else if (sfr_sel == IDX_W1_HI) begin
         rdata_nxt = dhi_r[1];
      end else if (sfr_sel == IDX_W2_LO) begin
         rdata_nxt = dlo_r[2];
      end else if (sfr_sel == IDX_W2_HI) begin
         rdata_nxt = dhi_r[2];
      end else if (sfr_sel == IDX_W3_LO) begin
         rdata_nxt = dlo_r[3];
      end else if (sfr_sel == IDX_W3_HI) begin
         rdata_nxt = dhi_r[3];
      end
   end

   // ----------------------------------------------------------
   // register stage
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r           <= ST_IDLE;
         cnt_r          <= '0;
         tmr_r          <= '0;
         en_r           <= 1'b0;
         mode_r         <= 3'h0;
         trig_r         <= 1'b0;
         rallow_r       <= 1'b0;
         ptsel_r        <= 1'b0;
         bclr_r         <= 1'b0;
         crst_r         <= RST_BYTE;
         addr_r         <= '0;
         dlo_r          <= '{default: RST_BYTE};
         dhi_r          <= '{default: RST_BYTE};
         sfr_rdata      <= RST_BYTE;
         cpu_halt       <= 1'b0;
         flash_rd_en    <= 1'b0;
         flash_erase_en <= 1'b0;
         flash_prog_en  <= 1'b0;
         chip_reset     <= 1'b0;
      end else begin
         st_r           <= st_nxt;
         cnt_r          <= cnt_nxt;
         tmr_r          <= tmr_nxt;
         en_r           <= en_nxt;
         mode_r         <= mode_nxt;
         trig_r         <= trig_nxt;
         rallow_r       <= rallow_nxt;
         ptsel_r        <= ptsel_nxt;
         bclr_r         <= bclr_nxt;
         crst_r         <= crst_nxt;
         addr_r         <= addr_nxt;
         dlo_r          <= dlo_nxt;
         dhi_r          <= dhi_nxt;
         sfr_rdata      <= rdata_nxt;
         cpu_halt       <= halt_nxt;
         flash_rd_en    <= rd_en_nxt;
         flash_erase_en <= er_en_nxt;
         flash_prog_en  <= pg_en_nxt;
         chip_reset     <= crst_p_nxt;
      end
   end

   assign flash_addr = addr_r;

   // page write buffer
   fspc_wbuf #(
      .WIDTH (16),
      .DEPTH (32),
      .AW    (PAGE_W)
   ) u_wbuf (
      .sys_clk (sys_clk),
      .we      (wb_we),
      .waddr   (wb_waddr),
      .wdata   (wb_wdata),
      .raddr   (wb_rd_idx),
      .rdata   (wb_rd_data)
   );

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic [CNT_W-1:0] op_len_r;
   always_ff @(posedge sys_clk) begin
      if (srst || (st_r == ST_IDLE) || (st_r == ST_CLEAR)) begin
         op_len_r <= '0;
      end else begin
         op_len_r <= op_len_r + CNT_W'(1);
      end
   end

   sequence s_write_end;
      (st_r == ST_WRITE) && (cnt_r == '0);
   endsequence
   sequence s_clear_walk;
      (st_r == ST_CLEAR) [*8];
   endsequence
   property p_clear_after_write;
      s_write_end |=> s_clear_walk;
   endproperty

   a_enable_hw_only: assert property ($rose(en_r) |-> $past(trig_r && pat_ok))
      else $error("enable rose without a matching unlock");
   a_enable_sw_clr: assert property (wr_ctrl && !sfr_wdata[B_EN] && !(trig_r && pat_ok &&
      mode_r == MODE_UNLOCK) |=> !en_r)
      else $error("software clear of enable lost");
   a_trig_expire: assert property (trig_r && (tmr_r == '0) |=> !trig_r)
      else $error("unlock trigger not cleared at timeout");
   a_write_length: assert property (s_write_end |-> op_len_r ==
      (ptsel_r ? WRITE1_CYC : WRITE0_CYC) - CNT_W'(1))
      else $error("write duration wrong");
   a_buf_autoclr: assert property (p_clear_after_write)
      else $error("buffer not cleared after write");
   a_halt_busy: assert property ((st_r inside {ST_READ, ST_ERASE, ST_WRITE}) |-> cpu_halt)
      else $error("core not halted during operation");
   a_read_gate: assert property ($rose(flash_rd_en) |-> $past(rallow_r))
      else $error("read started without read allow");
   a_addr_stop: assert property (w0hi_wr && (addr_r[PAGE_W-1:0] == PAGE_LAST)
      |=> $stable(addr_r))
      else $error("address passed page end");
   a_addr_step: assert property (w0hi_wr && (addr_r[PAGE_W-1:0] != PAGE_LAST)
      |=> addr_r == $past(addr_r) + ADDR_W'(1))
      else $error("address did not increment");
   a_chip_reset: assert property (sfr_wr && (sfr_sel == IDX_CHIP_RST) &&
      (sfr_wdata == CHIP_RST_KEY) |=> chip_reset)
      else $error("chip reset key ignored");
   a_clear_done: assert property ($rose(bclr_r) |-> ##[1:40] !bclr_r)
      else $error("buffer clear never finished");
   a_hi_reserved: assert property (sfr_sel == IDX_ADDR_HI |=> sfr_rdata[7:5] == 3'h0)
      else $error("reserved address bits read nonzero");

endmodule // fspc_ctrl

// file: tb/fspc_ctrl_tb.sv
// self-checking bench of the flash self-programming control
module fspc_ctrl_tb
   import fspc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // -------------------------------------------------------
   // shortened counts and bench signals
   // -------------------------------------------------------
   localparam int E0 = 20;
   localparam int W0 = 10;
   localparam int E1 = 25;
   localparam int W1 = 15;
   localparam int RD = 4;
   localparam int UW = 50;
   logic              sys_clk;
   logic              srst;
   logic [SEL_W-1:0]  sfr_sel;
   logic              sfr_wr;
   logic [7:0]        sfr_wdata;
   logic [7:0]        sfr_rdata;
   logic [ADDR_W-1:0] flash_addr;
   logic              flash_rd_en;
   logic              flash_erase_en;
   logic              flash_prog_en;
   logic [15:0]       flash_rd_data;
   logic [PAGE_W-1:0] wb_rd_idx;
   logic [15:0]       wb_rd_data;
   logic              cpu_halt;
   logic              chip_reset;
   logic [7:0]        d;
   int                n_errors;
   int                check_count;
   int                cycles;
   logic [3:0] t_sel [8] = '{4'h0, 4'h2, 4'h4, 4'h3, 4'h5, 4'h1, 4'h7, 4'hF};
   logic [7:0] t_wd  [8] = '{8'h80, 8'hFE, 8'hFF, 8'hA5, 8'h3C, 8'h12, 8'h77, 8'hAA};
   logic [7:0] t_ex  [8] = '{8'h00, 8'h02, 8'h1F, 8'hA5, 8'h3C, 8'h12, 8'h77, 8'h00};
   logic [7:0] pat   [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h41};

   fspc_ctrl #(
      .ERASE0_CYC (CNT_W'(E0)),
      .WRITE0_CYC (CNT_W'(W0)),
      .ERASE1_CYC (CNT_W'(E1)),
      .WRITE1_CYC (CNT_W'(W1)),
      .RD_CYC     (CNT_W'(RD)),
      .UNLOCK_WIN (TMR_W'(UW))
   ) i_dut (
      .sys_clk        (sys_clk),
      .srst           (srst),
      .sfr_sel        (sfr_sel),
      .sfr_wr         (sfr_wr),
      .sfr_wdata      (sfr_wdata),
      .sfr_rdata      (sfr_rdata),
      .flash_addr     (flash_addr),
      .flash_rd_en    (flash_rd_en),
      .flash_erase_en (flash_erase_en),
      .flash_prog_en  (flash_prog_en),
      .flash_rd_data  (flash_rd_data),
      .wb_rd_idx      (wb_rd_idx),
      .wb_rd_data     (wb_rd_data),
      .cpu_halt       (cpu_halt),
      .chip_reset     (chip_reset)
   );

   // -------------------------------------------------------
   // clock, hang guard and shared tasks
   // -------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // one register write, taken at the second edge
   task automatic wr(input logic [3:0] s, input logic [7:0] v);
      @(posedge sys_clk);
      sfr_sel   <= s;
      sfr_wr    <= 1'b1;
      sfr_wdata <= v;
      @(posedge sys_clk);
      sfr_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] s, output logic [7:0] v);
      @(posedge sys_clk);
      sfr_sel <= s;
      @(posedge sys_clk);
      #1;
      v = sfr_rdata;
   endtask

   task automatic wbchk(input logic [4:0] i, input logic [15:0] e);
      @(posedge sys_clk);
      wb_rd_idx <= i;
      @(posedge sys_clk);
      #1;
      chk(wb_rd_data, e);
   endtask

   // launch through the control register and time the core halt
   task automatic run(input logic [7:0] c, input logic [2:0] en3, input int expn);
      int n;
      n = 0;
      wr(4'h0, c);
      chk({13'h0, flash_rd_en, flash_erase_en, flash_prog_en}, {13'h0, en3});
      while (cpu_halt === 1'b1 && n < 200) begin
         n++;
         @(posedge sys_clk);
         #1;
      end
      chk(16'(n), 16'(expn));
   endtask

   // -------------------------------------------------------
   // main sequence
   // -------------------------------------------------------
   initial begin
      srst = 1'b1;
      sfr_sel = 4'h0;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      flash_rd_data = 16'hBEEF;
      wb_rd_idx = 5'h00;
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      rd(4'h0, d);
      chk({d, 3'h0, cpu_halt, flash_rd_en, flash_erase_en, flash_prog_en, chip_reset}, 16'h0000);
      chk({3'h0, flash_addr}, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr(t_sel[i], t_wd[i]);
         rd(t_sel[i], d);
         chk(d, t_ex[i]);
      end
      chk(16'(flash_addr), 16'h1FA5);
      wr(4'h1, 8'h55);
      chk(16'(chip_reset), 16'h0001);
      @(posedge sys_clk);
      #1;
      chk(16'(chip_reset), 16'h0000);
      run(8'h04, 3'b000, 0);
      // unlock: wrong pattern, expiry, armed-only check, then match
      wr(4'h0, 8'h68);
      for (int i = 0; i < 6; i++) wr(4'h7 + 4'(i), pat[i]);
      rd(4'h0, d);
      chk(d, 8'h68);
      repeat (UW + 10) @(posedge sys_clk);
      rd(4'h0, d);
      chk(d, 8'h60);
      wr(4'hC, 8'h40);
      rd(4'h0, d);
      chk(d, 8'h60);
      wr(4'h0, 8'h68);
      rd(4'h0, d);
      chk(d, 8'hE8);
      wr(4'h2, 8'h03);
      rd(4'h2, d);
      chk(d, 8'h03);
      repeat (40) @(posedge sys_clk);
      rd(4'h2, d);
      chk(d, 8'h02);
      wbchk(5'h00, 16'h0000);
      // buffer loads at the page end
      wr(4'h3, 8'h1E);
      wr(4'h4, 8'h00);
      wr(4'h5, 8'h34);
      rd(4'h3, d);
      chk(d, 8'h1E);
      wr(4'h6, 8'h12);
      rd(4'h3, d);
      chk(d, 8'h1F);
      wr(4'h5, 8'hCD);
      wr(4'h6, 8'hAB);
      rd(4'h3, d);
      chk(d, 8'h1F);
      wbchk(5'h1E, 16'h1234);
      wbchk(5'h1F, 16'hABCD);
      for (int c = 2; c < 8; c++) run({1'b1, 3'(c), 4'h4}, 3'b000, 0);
      run(8'h84, 3'b001, W1);
      repeat (40) @(posedge sys_clk);
      wbchk(5'h1F, 16'h0000);
      rd(4'h0, d);
      chk(d & 8'h84, 8'h80);
      wr(4'h2, 8'h00);
      run(8'h94, 3'b010, E0);
      wr(4'h0, 8'h82);
      run(8'hB3, 3'b100, RD);
      rd(4'h5, d);
      chk(d, 8'hEF);
      rd(4'h6, d);
      chk(d, 8'hBE);
      wr(4'h0, 8'h80);
      run(8'hB1, 3'b000, 0);
      wr(4'h0, 8'h00);
      rd(4'h0, d);
      chk(d, 8'h00);
      run(8'h04, 3'b000, 0);
      // reset in mid-run while a buffer clear is under way
      wr(4'h2, 8'h03);
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      rd(4'h2, d);
      chk(d, 8'h00);
      chk({3'h0, flash_addr}, 16'h0000);
      wr(4'h3, 8'h5A);
      chk({3'h0, flash_addr}, 16'h005A);
      wrap_up();
   end

endmodule // fspc_ctrl_tb
